// ==== hdl/sfb_buf.v ====
// Byte-lane word buffer with level count
`timescale 1ns/1ps
module sfb_buf #(
   parameter DW = 32,
   parameter BW = 4,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire rst,
   input wire wr_en,
   input wire [DW-1:0] wr_data,
   input wire [BW-1:0] wr_be,
   input wire rd_en,
   output reg [DW-1:0] rd_data,
   output reg [BW-1:0] rd_be,
   output wire full,
   output wire empty
);
   reg [DW-1:0] mem_data [0:DEPTH-1];
   reg [BW-1:0] mem_be [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire do_wr;
   wire do_rd;
   // Sized copy of the depth so the full compare needs no part-select of a parameter
   localparam [AW:0] DEPTH_C = DEPTH;
   assign full = (cnt_q == DEPTH_C);
   assign empty = (cnt_q == {(AW+1){1'b0}});
   assign do_wr = wr_en && !full;
   assign do_rd = rd_en && !empty;
   always @(posedge clk) begin
      if (do_wr) begin
         mem_data[wp_q] <= wr_data;
         mem_be[wp_q] <= wr_be;
      end
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         rd_data <= {DW{1'b0}};
         rd_be <= {BW{1'b0}};
      end else begin
         if (do_wr) begin
            wp_q <= wp_q + 1'b1;
         end
         if (do_rd) begin
            rd_data <= mem_data[rp_q];
            rd_be <= mem_be[rp_q];
            rp_q <= rp_q + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ==== hdl/sfb_regs.vh ====
// Constants for the synchronous FIFO bus handshake block
// Summary of operation
// RULE1: In single-channel mode the transmit-space flag is low only while the write buffer can take at least one more byte.
// RULE2: The master writes only in cycles where the transmit-space flag is low.
// RULE3: In single-channel mode the receive-data flag is low only while the read buffer holds at least one byte.
// RULE4: The master reads only in cycles where the receive-data flag is low.
// RULE5: In multi-channel mode the transmit-space flag pin carries a status-valid indication.
// RULE6: In multi-channel mode the receive-data flag pin carries a data-receive acknowledge.
// RULE7: In single-channel mode a low write strobe writes the word on the data bus into the device.
// RULE8: In multi-channel mode the write strobe carries the master's transaction request.
// RULE9: The write strobe is active low and a high level means no request.
// RULE10: In single-channel mode a low read strobe requests a read.
// RULE11: The shared data bus is 32 bits wide, bits 0 to 31.
// RULE12: Four byte-enable lines, bits 0 to 3, mark one byte lane each.
// RULE13: The device is held in reset while the chip reset input is low.
// RULE14: A low suspend/wakeup input is the asserted suspend/wakeup state.
// RULE15: The master's output-enable input lets the device drive the data bus; the device drives it in single-channel mode only.
// RULE16: Only lanes carrying valid data are enabled, and disabled lanes are ignored.
`ifndef SFB_REGS_VH
`define SFB_REGS_VH
`define SFB_DATA_W 32
`define SFB_BE_W 4
`define SFB_DEPTH 16
`define SFB_AW 4
`endif

// ==== hdl/sfb_top.v ====
// FIFO bus slave: handshake flags, strobes and data/byte-enable pins
`timescale 1ns/1ps
`include "sfb_regs.vh"
module sfb_top #(
   parameter DW = `SFB_DATA_W,
   parameter BW = `SFB_BE_W,
   parameter DEPTH = `SFB_DEPTH,
   parameter AW = `SFB_AW
) (
   input wire SYS_CLK,
   input wire RST,
   input wire RESET_IN_N,
   input wire MULTI_CH_MODE,
   input wire WAKE_IN_N,
   output wire SUSPEND_REQ,
   output reg TX_SPACE_FLAG_N,
   output reg RX_DATA_FLAG_N,
   input wire WR_STROBE_N,
   input wire RD_STROBE_N,
   input wire OUT_EN_N,
   input wire [DW-1:0] DATA_IN,
   output reg [DW-1:0] DATA_OUT,
   output wire DATA_OE,
   input wire [BW-1:0] BYTE_LANE_ENABLE_IN,
   output reg [BW-1:0] BYTE_LANE_ENABLE_OUT,
   output wire BYTE_LANE_ENABLE_OE,
   output wire [DW-1:0] RX_WORD,
   output wire [BW-1:0] RX_BE,
   output wire RX_VALID,
   input wire RX_READY,
   input wire [DW-1:0] TX_WORD,
   input wire [BW-1:0] TX_BE,
   input wire TX_VALID,
   output wire TX_READY,
   input wire STATUS_VALID,
   output reg TRANSACT_REQ
);
   // Chip reset pin joins the system reset; no clock needed to enter reset
   wire rst_all = RST | ~RESET_IN_N; // RULE13
   wire wb_full;
   wire wb_empty;
   wire rb_full;
   wire rb_empty;
   wire [DW-1:0] rb_data;
   wire [BW-1:0] rb_be;
   wire wr_req = ~WR_STROBE_N; // RULE9
   wire rd_req = ~RD_STROBE_N; // RULE10
   // Guard against a master ignoring the flags; the strobe is dropped then
   wire wr_take = !MULTI_CH_MODE && wr_req && !TX_SPACE_FLAG_N && !wb_full; // RULE7 RULE2
   wire rd_take = !MULTI_CH_MODE && rd_req && !RX_DATA_FLAG_N && !rb_empty; // RULE4
   wire [DW-1:0] wr_word;
   reg rd_vld_q;
   // Disabled lanes are stored as zero so the user side never sees stale bytes
   assign wr_word = mask_lanes(DATA_IN, BYTE_LANE_ENABLE_IN); // RULE16
   function [DW-1:0] mask_lanes;
      input [DW-1:0] d;
      input [BW-1:0] be;
      integer k;
      begin
         for (k = 0; k < DW; k = k + 1) begin
            mask_lanes[k] = d[k] & be[k/8];
         end
      end
   endfunction
   sfb_buf #(.DW(DW), .BW(BW), .DEPTH(DEPTH), .AW(AW)) u_wbuf (
      .clk(SYS_CLK),
      .rst(rst_all),
      .wr_en(wr_take),
      .wr_data(wr_word),
      .wr_be(BYTE_LANE_ENABLE_IN),
      .rd_en(RX_READY && !wb_empty && !rd_vld_q),
      .rd_data(RX_WORD),
      .rd_be(RX_BE),
      .full(wb_full),
      .empty(wb_empty)
   );
   always @(posedge SYS_CLK or posedge rst_all) begin
      if (rst_all) begin
         rd_vld_q <= 1'b0;
      end else begin
         rd_vld_q <= RX_READY && !wb_empty && !rd_vld_q;
      end
   end
   assign RX_VALID = rd_vld_q;
   sfb_buf #(.DW(DW), .BW(BW), .DEPTH(DEPTH), .AW(AW)) u_rbuf (
      .clk(SYS_CLK),
      .rst(rst_all),
      .wr_en(TX_VALID),
      .wr_data(TX_WORD),
      .wr_be(TX_BE),
      .rd_en(rd_take),
      .rd_data(rb_data),
      .rd_be(rb_be),
      .full(rb_full),
      .empty(rb_empty)
   );
   assign TX_READY = !rb_full;
   // Flags are registered; a write in the last free slot raises the flag at once
   always @(posedge SYS_CLK or posedge rst_all) begin
      if (rst_all) begin
         TX_SPACE_FLAG_N <= 1'b1;
         RX_DATA_FLAG_N <= 1'b1;
         TRANSACT_REQ <= 1'b0;
         DATA_OUT <= {DW{1'b0}};
         BYTE_LANE_ENABLE_OUT <= {BW{1'b0}};
      end else begin
         if (MULTI_CH_MODE) begin
            TX_SPACE_FLAG_N <= ~STATUS_VALID; // RULE5
            RX_DATA_FLAG_N <= ~wr_req; // RULE6
            TRANSACT_REQ <= wr_req; // RULE8
         end else begin
            TX_SPACE_FLAG_N <= wb_full || (wr_take && u_wbuf.cnt_q == DEPTH - 1); // RULE1
            RX_DATA_FLAG_N <= rb_empty || (rd_take && u_rbuf.cnt_q == 1); // RULE3
            TRANSACT_REQ <= 1'b0;
         end
         if (rd_take) begin
            DATA_OUT <= u_rbuf.mem_data[u_rbuf.rp_q]; // RULE11
            BYTE_LANE_ENABLE_OUT <= u_rbuf.mem_be[u_rbuf.rp_q]; // RULE12
         end
      end
   end
   // Device drives data and lanes only when the master opens output enable
   assign DATA_OE = !MULTI_CH_MODE && !OUT_EN_N; // RULE15
   assign BYTE_LANE_ENABLE_OE = DATA_OE; // RULE12
   assign SUSPEND_REQ = ~WAKE_IN_N; // RULE14
endmodule

// ==== sim/sfb_master.sv ====
// FIFO bus master model driving the strobes and write data
`timescale 1ns/1ps
module sfb_master(
   input wire clk,
   input wire do_wr,
   input wire do_rd,
   input wire tx_flag_n,
   input wire rx_flag_n,
   output reg wr_n,
   output reg rd_n,
   output reg [31:0] d,
   output reg [3:0] be
);
   reg [31:0] seq = 32'h0000_0001;
   initial begin
      wr_n = 1'h1;
      rd_n = 1'h1;
      d = 32'h0000_0000;
      be = 4'h0;
   end
   always @(posedge clk) begin
      if (!wr_n) seq = seq + 32'h0000_0001;
      #1;
      wr_n = !(do_wr && !tx_flag_n);
      rd_n = !(do_rd && !rx_flag_n);
      // Idle bus shows inverted data so stale words cannot match by luck
      d = wr_n ? ~d : seq;
      be = wr_n ? ~be : 4'hf;
   end
endmodule

// ==== sim/sfb_props.sv ====
// Checker of the FIFO bus handshake ports
`timescale 1ns/1ps
module sfb_props(
   input wire SYS_CLK,
   input wire RST,
   input wire RESET_IN_N,
   input wire MULTI_CH_MODE,
   input wire WAKE_IN_N,
   input wire SUSPEND_REQ,
   input wire TX_SPACE_FLAG_N,
   input wire RX_DATA_FLAG_N,
   input wire WR_STROBE_N,
   input wire STATUS_VALID,
   input wire TRANSACT_REQ,
   input wire OUT_EN_N,
   input wire DATA_OE,
   input wire BYTE_LANE_ENABLE_OE,
   input wire TX_READY
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // Mode must be steady across both edges, or the registered flags still hold the old meaning
   wire mc = MULTI_CH_MODE && RESET_IN_N && !RST;
   wire sc = !MULTI_CH_MODE && RESET_IN_N && !RST;
   a_pin_reset: assert property (!RESET_IN_N |-> TX_SPACE_FLAG_N && RX_DATA_FLAG_N)
      else $error("flags not idle in reset");
   a_suspend_level: assert property (SUSPEND_REQ == !WAKE_IN_N)
      else $error("suspend level wrong");
   a_multi_ack: assert property (mc && $past(mc) |-> RX_DATA_FLAG_N == $past(WR_STROBE_N))
      else $error("ack not following request");
   a_multi_txn: assert property (mc && $past(mc) |-> TRANSACT_REQ == !$past(WR_STROBE_N))
      else $error("transaction request wrong");
   a_status_flag: assert property (mc && $past(mc) |-> TX_SPACE_FLAG_N == !$past(STATUS_VALID))
      else $error("status valid not shown");
   a_single_txn: assert property (sc && $past(sc) |-> !TRANSACT_REQ)
      else $error("request outside multi mode");
   a_oe_off: assert property (OUT_EN_N |-> !DATA_OE)
      else $error("bus driven without enable");
   a_lane_oe: assert property (BYTE_LANE_ENABLE_OE == DATA_OE)
      else $error("lane enable drive mismatch");
   a_full_flag: assert property (sc && !TX_READY |=> !RX_DATA_FLAG_N)
      else $error("full buffer shows no data");
endmodule
bind sfb_top sfb_props u_props(.*);

// ==== sim/sfb_top_bench.sv ====
// Self-checking bench of the FIFO bus handshake block
`timescale 1ns/1ps
module sfb_top_bench;
   reg SYS_CLK = 0, RST = 1, RESET_IN_N = 1, MULTI_CH_MODE = 0, WAKE_IN_N = 1, OUT_EN_N = 1;
   reg RX_READY = 0, TX_VALID = 0, STATUS_VALID = 0, do_wr = 0, do_rd = 0, p;
   reg [31:0] TX_WORD = 32'h0000_0000;
   reg [3:0] TX_BE = 4'hf;
   wire WR_STROBE_N, RD_STROBE_N, SUSPEND_REQ, TX_SPACE_FLAG_N, RX_DATA_FLAG_N, DATA_OE;
   wire BYTE_LANE_ENABLE_OE, RX_VALID, TX_READY, TRANSACT_REQ;
   wire [31:0] DATA_IN, DATA_OUT, RX_WORD;
   wire [3:0] BYTE_LANE_ENABLE_IN, BYTE_LANE_ENABLE_OUT, RX_BE;
   int miscompares = 0, total_checks = 0, n;
   sfb_top DUT(.*);
   sfb_master u_m(.clk(SYS_CLK), .do_wr(do_wr), .do_rd(do_rd), .tx_flag_n(TX_SPACE_FLAG_N),
      .rx_flag_n(RX_DATA_FLAG_N), .wr_n(WR_STROBE_N), .rd_n(RD_STROBE_N), .d(DATA_IN),
      .be(BYTE_LANE_ENABLE_IN));
   initial forever #12.5 SYS_CLK = ~SYS_CLK;
   task chk(input [31:0] g, input [31:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task summarize;
      $display("checks %0d errors %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge SYS_CLK);
      #2;
   endtask
   task t_write;
      do_wr = 1; cyc(24); do_wr = 0;
      chk(TX_SPACE_FLAG_N, 1);
      RX_READY = 1; n = 0;
      repeat (60) begin
         cyc(1);
         if (RX_VALID === 1'h1) begin n++; chk(RX_WORD, n); chk(RX_BE, 4'hf); end
      end
      chk(n, 16); chk(TX_SPACE_FLAG_N, 0); RX_READY = 0;
   endtask
   task t_read;
      for (int i = 0; i < 16; i++) begin TX_WORD = 32'hA5A5_0000 + i; TX_VALID = 1; cyc(1); end
      TX_VALID = 0; chk(TX_READY, 0);
      OUT_EN_N = 0; do_rd = 1; n = 0; p = 0;
      repeat (40) begin
         cyc(1);
         if (p) begin chk(DATA_OUT, 32'hA5A5_0000 + n); chk(BYTE_LANE_ENABLE_OUT, 4'hf); n++; end
         p = !RD_STROBE_N;
      end
      chk(n, 16); chk(RX_DATA_FLAG_N, 1); chk(DATA_OE, 1); do_rd = 0; OUT_EN_N = 1;
   endtask
   task t_multi;
      MULTI_CH_MODE = 1; STATUS_VALID = 1; cyc(2);
      chk(TX_SPACE_FLAG_N, 0); do_wr = 1; cyc(3);
      chk(TRANSACT_REQ, 1); chk(RX_DATA_FLAG_N, 0);
      do_wr = 0; STATUS_VALID = 0; cyc(2);
      chk(TRANSACT_REQ, 0); chk(TX_SPACE_FLAG_N, 1); MULTI_CH_MODE = 0;
   endtask
   task t_pin;
      RESET_IN_N = 0; WAKE_IN_N = 0; cyc(1);
      chk(TX_SPACE_FLAG_N, 1); chk(RX_DATA_FLAG_N, 1); chk(SUSPEND_REQ, 1);
      RESET_IN_N = 1; WAKE_IN_N = 1; cyc(2);
      chk(TX_SPACE_FLAG_N, 0); chk(SUSPEND_REQ, 0);
   endtask
   initial begin
      cyc(2); RST = 0; cyc(2);
      t_write; t_read; t_multi; t_pin;
      summarize;
   end
   initial begin
      #20000;
      miscompares++;
      summarize;
   end
endmodule
